/* qsi_far_end.sv */
// Serial engines and modem pins on the far side of the register face
`timescale 1ns/1ps

module qsi_far_end
(
    input  wire logic                                sys_clk,
    output qsi_pkg::qsi_rx_t    [qsi_pkg::CH_N-1:0] rx_in,
    output logic [qsi_pkg::CH_N-1:0]                tx_taken,
    output qsi_pkg::qsi_modem_t [qsi_pkg::CH_N-1:0] modem_pin
);
    import qsi_pkg::*;

    initial
    begin
        rx_in     = '0;
        tx_taken  = '0;
        modem_pin = '0;
    end

    // Data lines move off the byte once valid drops
    task automatic send(input int ch, input logic [7:0] b,
                        input logic [2:0] f);
        @(posedge sys_clk);
        rx_in[ch] <= '{1'b1, b, f[0], f[1], f[2]};
        @(posedge sys_clk);
        rx_in[ch] <= '{1'b0, ~b, 1'b0, 1'b0, 1'b0};
    endtask : send

    task automatic take(input int ch);
        @(posedge sys_clk);
        tx_taken[ch] <= 1'b1;
        @(posedge sys_clk);
        tx_taken[ch] <= 1'b0;
    endtask : take

    task automatic modem(input int ch, input logic [3:0] m);
        @(posedge sys_clk);
        modem_pin[ch] <= qsi_modem_t'(m);
    endtask : modem
endmodule : qsi_far_end

/* qsi_pkg.sv */
// Constants and carrier types for the quad serial status and interrupt block
package qsi_pkg;

    localparam int CH_N   = 4;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int EV_W   = 2 * CH_N;

    // Register addresses as printed
    localparam logic [ADDR_W-1:0] STATUS_ADDR [CH_N] =
        '{16'hBF04, 16'hBF14, 16'hBF24, 16'hBF34};
    localparam logic [ADDR_W-1:0] DATA_ADDR [CH_N] =
        '{16'hBF06, 16'hBF16, 16'hBF26, 16'hBF36};
    localparam logic [ADDR_W-1:0] IRQ_SRC_ADDR = 16'hBF40;
    localparam logic [ADDR_W-1:0] CH_EN_ADDR   = 16'hBF42;
    localparam logic [ADDR_W-1:0] EVENT_ADDR   = 16'hBF44;
    localparam logic [ADDR_W-1:0] MASK_ADDR    = 16'hBF46;

    // Channel status word layout
    localparam int ST_TX_EMPTY = 0;
    localparam int ST_RX_FULL  = 1;
    localparam int ST_CTS      = 2;
    localparam int ST_DSR      = 3;
    localparam int ST_DCD      = 4;
    localparam int ST_RING     = 5;
    localparam int ST_PARITY   = 6;
    localparam int ST_OVERRUN  = 7;
    localparam int ST_BREAK    = 8;
    localparam int ST_FRAME    = 9;

    // Enable register layout
    localparam int EN_LSB       = 0;
    localparam int IRQ_MODE_BIT = 7;

    // Event register layout: rx events low nibble, tx events high nibble
    localparam int EV_RX_LSB = 0;
    localparam int EV_TX_LSB = CH_N;

    // Reset values
    localparam logic [CH_N-1:0]   CH_EN_RESET = 4'h0;
    localparam logic [EV_W-1:0]   MASK_RESET  = 8'hFF;
    localparam logic [EV_W-1:0]   EV_RESET    = 8'h00;
    localparam logic [BYTE_W-1:0] BYTE_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] WORD_ZERO   = 16'h0000;

    // Interrupt source codes
    localparam logic [3:0] IS_NONE    = 4'h0;
    localparam logic [3:0] IS_RX_BASE = 4'h1;
    localparam logic [3:0] IS_TX_BASE = 4'h5;

    typedef struct packed {
        logic              valid;
        logic [BYTE_W-1:0] data;
        logic              parity_err;
        logic              frame_err;
        logic              break_det;
    } qsi_rx_t;

    typedef struct packed {
        logic              load;
        logic [BYTE_W-1:0] data;
    } qsi_tx_t;

    typedef struct packed {
        logic ring;
        logic dcd;
        logic dsr;
        logic cts;
    } qsi_modem_t;

endpackage : qsi_pkg

/* qsi_quad_serial.sv */
// Register face, status flags and interrupt source of a four channel serial unit
//
// Contract
// - Status bit shows 1 when last received character failed parity.
// - ring_detect_flag follows the ring input.
// - carrier_detect_flag follows the carrier detect input.
// - set_ready_flag follows the data set ready input.
// - clear_to_send_flag follows the clear to send input.
// - rx_full_flag is 1 while an unread character waits.
// - tx_empty_flag is 1 while the transmit buffer can take a byte.
// - Reading receive data clears rx_full_flag, break_flag, framing_error_flag.
// - One data offset per channel: write sends tx_byte, read returns rx_byte.
// - irq_source_code: 0 none, 1-4 rx full, 5-8 tx empty.
// - Interrupt raised on rising edge of rx full or tx empty.
// - Channel 1 highest priority; code tracks sources as they are serviced.
// - framing_error_flag and break_flag set on frame error and break.
`timescale 1ns/1ps

module qsi_quad_serial
(
    input  wire logic                                  sys_clk,
    input  wire logic                                  rst,
    input  wire logic [qsi_pkg::ADDR_W-1:0]            reg_addr,
    input  wire logic [qsi_pkg::DATA_W-1:0]            reg_wdata,
    input  wire logic                                  reg_wr,
    input  wire logic                                  reg_rd,
    output logic      [qsi_pkg::DATA_W-1:0]            reg_rdata,
    input  wire qsi_pkg::qsi_rx_t    [qsi_pkg::CH_N-1:0] rx_in,
    input  wire logic [qsi_pkg::CH_N-1:0]              tx_taken,
    output qsi_pkg::qsi_tx_t         [qsi_pkg::CH_N-1:0] tx_out,
    input  wire qsi_pkg::qsi_modem_t [qsi_pkg::CH_N-1:0] modem_pin,
    output logic      [qsi_pkg::CH_N-1:0]              channel_enable,
    output logic      [3:0]                            irq_source_code,
    output logic                                       irq,
    output logic      [qsi_pkg::CH_N-1:0]              chan_irq
);
    import qsi_pkg::*;

    logic [CH_N-1:0]   chan_en_reg;
    logic              irq_mode_reg;
    logic [EV_W-1:0]   event_reg;
    logic [EV_W-1:0]   event_next;
    logic [EV_W-1:0]   mask_reg;
    logic [EV_W-1:0]   event_set;
    logic [EV_W-1:0]   event_service;
    logic [EV_W-1:0]   event_w1c;
    logic [EV_W-1:0]   live_events;
    logic [DATA_W-1:0] rdata_next;

    logic [CH_N-1:0]   rx_full_vec;
    logic [CH_N-1:0]   tx_empty_vec;
    logic [CH_N-1:0]   rx_rise;
    logic [CH_N-1:0]   tx_rise;
    logic [CH_N-1:0]   data_rd_hit;
    logic [CH_N-1:0]   data_wr_hit;
    logic [CH_N-1:0]   status_rd_hit;
    logic [DATA_W-1:0] status_word [CH_N];
    logic [BYTE_W-1:0] rx_byte_vec [CH_N];

    genvar i;

    generate
        for (i = 0; i < CH_N; i++)
        begin : g_chan
            logic [BYTE_W-1:0] rx_byte_reg;
            logic              rx_full_reg;
            logic              parity_reg;
            logic              frame_reg;
            logic              break_reg;
            logic              overrun_reg;
            logic              tx_empty_reg;
            logic              tx_load_reg;
            logic [BYTE_W-1:0] tx_byte_reg;
            logic              rx_full_dly_reg;
            logic              tx_empty_dly_reg;
            logic [3:0]        m1_reg;
            logic [3:0]        m2_reg;
            logic [3:0]        m3_reg;
            logic [3:0]        modem_reg;
            logic [3:0]        modem_next;
            logic              rx_take;

            // A disabled channel ignores received bytes; tx_taken still sets its tx_empty_reg
            assign rx_take = chan_en_reg[i] & rx_in[i].valid;

            assign data_rd_hit[i]   = reg_rd & (reg_addr == DATA_ADDR[i])
                                      & chan_en_reg[i];
            // Writes while the buffer is still busy are dropped, not queued
            assign data_wr_hit[i]   = reg_wr & (reg_addr == DATA_ADDR[i])
                                      & chan_en_reg[i] & tx_empty_reg;
            assign status_rd_hit[i] = reg_rd & (reg_addr == STATUS_ADDR[i]);

            always_ff @(posedge sys_clk)
            begin
                if (rst)
                    rx_byte_reg <= BYTE_RESET;
                else if (rx_take)
                    rx_byte_reg <= rx_in[i].data;
            end

            // Arrival wins over a read in the same cycle
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                    rx_full_reg <= 1'b0;
                else if (rx_take)
                    rx_full_reg <= 1'b1;
                else if (data_rd_hit[i])
                    rx_full_reg <= 1'b0;
            end

            always_ff @(posedge sys_clk)
            begin
                if (rst)
                    parity_reg <= 1'b0;
                else if (rx_take)
                    parity_reg <= rx_in[i].parity_err;
            end

            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    frame_reg <= 1'b0;
                    break_reg <= 1'b0;
                end
                else
                begin
                    if (rx_take & rx_in[i].frame_err)
                        frame_reg <= 1'b1;
                    else if (data_rd_hit[i])
                        frame_reg <= 1'b0;
                    if (rx_take & rx_in[i].break_det)
                        break_reg <= 1'b1;
                    else if (data_rd_hit[i])
                        break_reg <= 1'b0;
                end
            end

            // Overrun clears on a status read; a new overrun in that cycle wins
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                    overrun_reg <= 1'b0;
                else if (rx_take & rx_full_reg & ~data_rd_hit[i])
                    overrun_reg <= 1'b1;
                else if (status_rd_hit[i])
                    overrun_reg <= 1'b0;
            end

            always_ff @(posedge sys_clk)
            begin
                if (rst)
                    tx_empty_reg <= 1'b1;
                else if (data_wr_hit[i])
                    tx_empty_reg <= 1'b0;
                else if (tx_taken[i])
                    tx_empty_reg <= 1'b1;
            end

            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    tx_load_reg <= 1'b0;
                    tx_byte_reg <= BYTE_RESET;
                end
                else
                begin
                    tx_load_reg <= data_wr_hit[i];
                    if (data_wr_hit[i])
                        tx_byte_reg <= reg_wdata[BYTE_W-1:0];
                end
            end

            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    rx_full_dly_reg  <= 1'b0;
                    tx_empty_dly_reg <= 1'b1;
                end
                else
                begin
                    rx_full_dly_reg  <= rx_full_reg;
                    tx_empty_dly_reg <= tx_empty_reg;
                end
            end

            // Edges only, so a buffer that stays full does not re-raise
            assign rx_rise[i] = rx_full_reg & ~rx_full_dly_reg;
            assign tx_rise[i] = tx_empty_reg & ~tx_empty_dly_reg;

            // Modem pins: three stages, a change counts once stages 2 and 3 agree
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    m1_reg <= 4'h0;
                    m2_reg <= 4'h0;
                    m3_reg <= 4'h0;
                end
                else
                begin
                    m1_reg <= modem_pin[i];
                    m2_reg <= m1_reg;
                    m3_reg <= m2_reg;
                end
            end

            assign modem_next = (m3_reg & ~(m2_reg ^ m3_reg))
                                | (modem_reg & (m2_reg ^ m3_reg));

            always_ff @(posedge sys_clk)
            begin
                if (rst)
                    modem_reg <= 4'h0;
                else
                    modem_reg <= modem_next;
            end

            always_comb
            begin
                status_word[i] = WORD_ZERO;
                if (chan_en_reg[i])
                begin
                    status_word[i][ST_TX_EMPTY] = tx_empty_reg;
                    status_word[i][ST_RX_FULL]  = rx_full_reg;
                    status_word[i][ST_CTS]      = modem_reg[0];
                    status_word[i][ST_DSR]      = modem_reg[1];
                    status_word[i][ST_DCD]      = modem_reg[2];
                    status_word[i][ST_RING]     = modem_reg[3];
                    status_word[i][ST_PARITY]   = parity_reg;
                    status_word[i][ST_OVERRUN]  = overrun_reg;
                    status_word[i][ST_BREAK]    = break_reg;
                    status_word[i][ST_FRAME]    = frame_reg;
                end
            end

            assign rx_full_vec[i]  = rx_full_reg;
            assign tx_empty_vec[i] = tx_empty_reg;
            assign rx_byte_vec[i]  = rx_byte_reg;
            assign tx_out[i].load  = tx_load_reg;
            assign tx_out[i].data  = tx_byte_reg;
        end
    endgenerate

    // Enable register is write-only; its bits steer every channel
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            chan_en_reg  <= CH_EN_RESET;
            irq_mode_reg <= 1'b0;
        end
        else if (reg_wr & (reg_addr == CH_EN_ADDR))
        begin
            chan_en_reg  <= reg_wdata[EN_LSB +: CH_N];
            irq_mode_reg <= reg_wdata[IRQ_MODE_BIT];
        end
    end

    assign channel_enable = chan_en_reg;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            mask_reg <= MASK_RESET;
        else if (reg_wr & (reg_addr == MASK_ADDR))
            mask_reg <= reg_wdata[EV_W-1:0];
    end

    assign event_set     = {tx_rise & chan_en_reg, rx_rise & chan_en_reg};
    assign event_service = {data_wr_hit, data_rd_hit};
    assign event_w1c     = (reg_wr & (reg_addr == EVENT_ADDR))
                           ? reg_wdata[EV_W-1:0] : EV_RESET;

    // Servicing a source or writing one retires it; a new edge wins
    assign event_next = (event_reg & ~event_service & ~event_w1c)
                        | event_set;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            event_reg <= EV_RESET;
        else
            event_reg <= event_next;
    end

    assign live_events = event_reg & mask_reg & {chan_en_reg, chan_en_reg};

    // Scan from channel 4 down to channel 1 so the lowest channel always wins
    function automatic logic [3:0] qsi_source(input logic [EV_W-1:0] ev);
        logic [3:0] code;
        code = IS_NONE;
        for (int c = CH_N - 1; c >= 0; c--)
        begin
            if (ev[EV_TX_LSB + c])
                code = IS_TX_BASE + 4'(c);
            if (ev[EV_RX_LSB + c])
                code = IS_RX_BASE + 4'(c);
        end
        return code;
    endfunction : qsi_source

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irq_source_code <= IS_NONE;
        else
            irq_source_code <= qsi_source(live_events);
    end

    assign irq = (irq_source_code != IS_NONE);

    generate
        for (i = 0; i < CH_N; i++)
        begin : g_chan_irq
            assign chan_irq[i] = irq_mode_reg
                                 & (live_events[EV_RX_LSB + i]
                                    | live_events[EV_TX_LSB + i]);
        end
    endgenerate

    always_comb
    begin
        rdata_next = WORD_ZERO;
        for (int c = 0; c < CH_N; c++)
        begin
            if (reg_addr == STATUS_ADDR[c])
                rdata_next = status_word[c];
            if ((reg_addr == DATA_ADDR[c]) & chan_en_reg[c])
                rdata_next = {8'h00, rx_byte_vec[c]};
        end
        if (reg_addr == IRQ_SRC_ADDR)
            rdata_next = {12'h000, irq_source_code};
        if (reg_addr == EVENT_ADDR)
            rdata_next = {8'h00, event_reg};
        if (reg_addr == MASK_ADDR)
            rdata_next = {8'h00, mask_reg};
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            reg_rdata <= WORD_ZERO;
        else if (reg_rd)
            reg_rdata <= rdata_next;
        else
            reg_rdata <= WORD_ZERO;
    end

endmodule : qsi_quad_serial

/* qsi_quad_serial_bench.sv */
// Register level tests of the quad serial status and interrupt block
`timescale 1ns/1ps

module qsi_quad_serial_bench;
    import qsi_pkg::*;

    logic                    sys_clk = 1'b0;
    logic                    rst;
    logic [ADDR_W-1:0]       reg_addr;
    logic [DATA_W-1:0]       reg_wdata;
    logic                    reg_wr;
    logic                    reg_rd;
    logic [DATA_W-1:0]       reg_rdata;
    qsi_rx_t    [CH_N-1:0]   rx_in;
    logic [CH_N-1:0]         tx_taken;
    qsi_tx_t    [CH_N-1:0]   tx_out;
    qsi_modem_t [CH_N-1:0]   modem_pin;
    logic [CH_N-1:0]         channel_enable;
    logic [3:0]              irq_source_code;
    logic                    irq;
    logic [CH_N-1:0]         chan_irq;
    int                      error_cnt = 0;
    int                      samples_checked = 0;
    int                      cycles = 0;

    always #2.5 sys_clk = ~sys_clk;

    qsi_far_end far (.sys_clk(sys_clk), .rx_in(rx_in), .tx_taken(tx_taken),
                     .modem_pin(modem_pin));

    qsi_quad_serial uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_in(rx_in), .tx_taken(tx_taken),
        .tx_out(tx_out), .modem_pin(modem_pin),
        .channel_enable(channel_enable), .irq_source_code(irq_source_code),
        .irq(irq), .chan_irq(chan_irq));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd

    task automatic code(input int n, input logic [3:0] e);
        repeat (n) @(posedge sys_clk);
        #1 chk({11'h000, irq, irq_source_code}, {11'h000, e != 4'h0, e});
    endtask : code

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    initial
    begin
        logic [2:0]  f;
        logic [15:0] pf;
        rst = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rd(STATUS_ADDR[0], 16'h0000);
        rd(16'hBF48, 16'h0000);
        wr(CH_EN_ADDR, 16'h000F);
        rd(CH_EN_ADDR, 16'h0000);
        wr(EVENT_ADDR, 16'h00FF);
        code(4, 4'h0);
        $display("test reset done");
        for (int c = 0; c < CH_N; c++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                far.modem(c, 4'h1 << k);
                repeat (6) @(posedge sys_clk);
                rd(STATUS_ADDR[c], 16'h0001 | (16'h0004 << k));
            end
            far.modem(c, 4'h0);
        end
        $display("test modem done");
        for (int c = 0; c < CH_N; c++)
        begin
            f = (c < 3) ? 3'b001 << c : 3'b000;
            far.send(c, 8'hC0 + 8'(c), f);
            code(6, 4'(c + 1));
            rd(STATUS_ADDR[c], {6'h0, f[1], f[2], 1'b0, f[0], 6'h03});
            rd(DATA_ADDR[c], 16'(8'hC0 + c));
            rd(STATUS_ADDR[c], {9'h0, f[0], 6'h01});
            code(3, 4'h0);
        end
        far.send(2, 8'h33, 3'b000);
        far.send(1, 8'h22, 3'b000);
        code(6, 4'h2);
        rd(DATA_ADDR[1], 16'h0022);
        code(3, 4'h3);
        rd(DATA_ADDR[2], 16'h0033);
        code(3, 4'h0);
        $display("test receive done");
        for (int c = 0; c < CH_N; c++)
        begin
            pf = (c == 0) ? 16'h0040 : 16'h0000;
            wr(DATA_ADDR[c], 16'(8'hA0 + c));
            // Second byte must bounce while the first is still held
            wr(DATA_ADDR[c], 16'h0055);
            #1 chk({8'h00, tx_out[c].data}, 16'(8'hA0 + c));
            rd(STATUS_ADDR[c], pf);
            repeat (10) @(posedge sys_clk);
            far.take(c);
            code(5, 4'(c + 5));
            rd(STATUS_ADDR[c], pf | 16'h0001);
            wr(EVENT_ADDR, 16'h0010 << c);
            code(3, 4'h0);
        end
        $display("test transmit done");
        wr(MASK_ADDR, 16'h0000);
        far.send(0, 8'h5A, 3'b000);
        code(6, 4'h0);
        rd(EVENT_ADDR, 16'h0001);
        wr(MASK_ADDR, 16'h00FF);
        code(3, 4'h1);
        rd(DATA_ADDR[0], 16'h005A);
        code(3, 4'h0);
        $display("test mask done");
        // Mode bit on: the per channel line follows the live event
        wr(CH_EN_ADDR, 16'h008F);
        far.send(3, 8'h44, 3'b000);
        code(6, 4'h4);
        chk({12'h000, chan_irq}, 16'h0008);
        rd(DATA_ADDR[3], 16'h0044);
        code(3, 4'h0);
        chk({12'h000, chan_irq}, 16'h0000);
        $display("test channel irq done");
        wr(CH_EN_ADDR, 16'h000E);
        rd(STATUS_ADDR[0], 16'h0000);
        wr(DATA_ADDR[0], 16'h0077);
        #1 chk({15'h0, tx_out[0].load}, 16'h0000);
        $display("test disable done");
        report_and_stop();
    end
endmodule : qsi_quad_serial_bench

/* qsi_quad_serial_properties.sv */
// Concurrent checks on the quad serial register face
`timescale 1ns/1ps

module qsi_checker
(
    input wire logic                                sys_clk,
    input wire logic                                rst,
    input wire logic [qsi_pkg::ADDR_W-1:0]          reg_addr,
    input wire logic [qsi_pkg::DATA_W-1:0]          reg_wdata,
    input wire logic                                reg_wr,
    input wire logic                                reg_rd,
    input wire logic [qsi_pkg::DATA_W-1:0]          reg_rdata,
    input wire qsi_pkg::qsi_rx_t [qsi_pkg::CH_N-1:0] rx_in,
    input wire qsi_pkg::qsi_tx_t [qsi_pkg::CH_N-1:0] tx_out,
    input wire logic [qsi_pkg::CH_N-1:0]            channel_enable,
    input wire logic [3:0]                          irq_source_code,
    input wire logic                                irq
);
    import qsi_pkg::*;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    irq_follows_code_a:
    assert property (irq == (irq_source_code != IS_NONE))
        else $error("irq differs from source code");
    code_in_range_a:
    assert property (irq_source_code <= 4'h8)
        else $error("source code out of range");
    rdata_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata == WORD_ZERO)
        else $error("read data without read");
    load_cause_a:
    assert property (tx_out[0].load |-> $past(reg_wr) && $past(channel_enable[0])
        && $past(reg_addr) == DATA_ADDR[0]
        && tx_out[0].data == $past(reg_wdata[7:0]))
        else $error("load without matching write");
    load_pulse_a:
    assert property (tx_out[0].load |=> !tx_out[0].load)
        else $error("second load while buffer full");
    enable_write_a:
    assert property (reg_wr && reg_addr == CH_EN_ADDR
        |=> channel_enable == $past(reg_wdata[3:0]))
        else $error("enable not taken");
    enable_wo_a:
    assert property (reg_rd && reg_addr == CH_EN_ADDR |=> reg_rdata == WORD_ZERO)
        else $error("enable register readable");
    rx_read_clears_a:
    assert property (reg_rd && reg_addr == DATA_ADDR[0] && channel_enable[0]
        && !rx_in[0].valid |-> ##2 irq_source_code != IS_RX_BASE)
        else $error("rx source kept after read");
    reset_clear_a:
    assert property ($fell(rst) |-> channel_enable == CH_EN_RESET
        && irq_source_code == IS_NONE)
        else $error("outputs not cleared by reset");

    cover property (irq_source_code == IS_RX_BASE);
    cover property (irq_source_code == IS_TX_BASE);
    cover property (tx_out[0].load);
endmodule : qsi_checker

bind qsi_quad_serial qsi_checker u_chk
(
    .sys_clk         (sys_clk),
    .rst             (rst),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .rx_in           (rx_in),
    .tx_out          (tx_out),
    .channel_enable  (channel_enable),
    .irq_source_code (irq_source_code),
    .irq             (irq)
);
